// ===== dsw_consts.vh
// dsw_consts.vh: constants for the serial write port of a 16-bit dac.
// assumes it is included by bare name from the design files.
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH

// frame geometry
`define DSW_FRAME_BITS      24
`define DSW_CNT_W           5
`define DSW_DATA_W          16

// field positions inside the received word
`define DSW_RST_LOAD_BIT    22
`define DSW_MODE_HI         21
`define DSW_MODE_LO         20
`define DSW_DATA_HI         15
`define DSW_DATA_LO         0

// power-on codes
`define DSW_CODE_ZERO       16'h0000
`define DSW_CODE_MID        16'h8000
`define DSW_MODE_NORMAL     2'h0
`define DSW_SHIFT_CLEAR     24'h00_0000

// host serial clock ceiling and ref_clk rate, kept for the bench, not used by logic
`define DSW_SCLK_MAX_MHZ    30
`define DSW_REF_CLK_MHZ     40

`endif

// ===== dsw_sync2.v
// dsw_sync2.v: two-stage synchroniser for a group of independent levels.
// assumes each bit is a slow level; no bus coherency is implied.
`timescale 1ns/1ps
`default_nettype none

module dsw_sync2 #(
	parameter WIDTH = 3
) (
	input  wire             ref_clk,
	input  wire             nrst,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// first stage feeds only the second stage
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule // dsw_sync2

`default_nettype wire

// ===== dsw_write_port.v
// dsw_write_port.v: write-only three-wire serial input of a 16-bit dac.
// assumes the host pins are asynchronous to ref_clk and that the serial
// clock runs well below a quarter of ref_clk so every edge is seen.
// a sync line already low when reset ends counts as a fresh fall.
// update_pulse and abort_pulse each last one ref_clk cycle.
// reset_code is an output only and never reloads the dac code.
//
// Operation
// - frame sync low-going edge arms the shift register for a word.
// - while sync is low, each serial clock fall up to the 24th captures one data bit.
// - the input shift register is 24 bits; a word is 24 bits.
// - update length conflict resolved: update on the 24th fall.
// - sync rising before the update edge aborts the partial write.
// - power-on code is zero or midscale by variant, held until a write.
// - on the 24th fall, latch last bit and apply code and mode.
// - bits 21 and 20 select normal or one of three power-down modes.
// - bit 22 also loads the data into a persistent reset-code register.
// - an abort clears the shift register, leaves code and mode alone.
`timescale 1ns/1ps
`default_nettype none
`include "dsw_consts.vh"

module dsw_write_port #(
	parameter RESET_TO_MID = 0,
	parameter FRAME_BITS   = `DSW_FRAME_BITS
) (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire        frame_sync_n,
	input  wire        serial_clock,
	input  wire        serial_data_in,
	output wire [15:0] dac_code,
	output wire [1:0]  power_mode_sel,
	output wire        power_down,
	output wire [15:0] reset_code,
	output wire        update_pulse,
	output wire        abort_pulse,
	output wire        frame_active
);

	// power-on code picked by the build variant
	localparam [15:0] POR_CODE = (RESET_TO_MID != 0) ?
		`DSW_CODE_MID : `DSW_CODE_ZERO;
	// index of the last bit; only the low five bits reach the counter
	localparam integer LAST_IDX = FRAME_BITS - 1;

	// frame states, one-hot
	localparam [2:0] ST_IDLE  = 3'b001; // waiting for a fresh sync fall
	localparam [2:0] ST_SHIFT = 3'b010; // collecting bits
	localparam [2:0] ST_DONE  = 3'b100; // word applied, sync still low

	wire [2:0] pins_sync;
	wire       sync_n_s;
	wire       sclk_s;
	wire       sdi_s;

	reg        sync_n_d_reg;
	reg        sclk_d_reg;
	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg [23:0] shift_reg;
	reg [23:0] shift_next;
	reg [4:0]  count_reg;
	reg [4:0]  count_next;
	reg [15:0] code_reg;
	reg [15:0] code_next;
	reg [1:0]  mode_reg;
	reg [1:0]  mode_next;
	reg [15:0] rcode_reg;
	reg [15:0] rcode_next;
	reg        upd_reg;
	reg        upd_next;
	reg        abt_reg;
	reg        abt_next;

	wire       sync_fall;
	wire       sclk_fall;
	wire [23:0] word_in;

	// data field of a received word, used for dac and reset codes
	function [15:0] code_field;
		input [23:0] word;
		begin
			code_field = word[`DSW_DATA_HI:`DSW_DATA_LO];
		end
	endfunction

	// bring all three host pins into the ref_clk domain
	dsw_sync2 #(
		.WIDTH (3)
	) u_pin_sync (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_in ({frame_sync_n, serial_clock, serial_data_in}),
		.sync_out (pins_sync)
	);

	assign sync_n_s = pins_sync[2];
	assign sclk_s   = pins_sync[1];
	assign sdi_s    = pins_sync[0];

	// edge history, taken after the synchroniser only
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync_n_d_reg <= 1'b1;
			sclk_d_reg   <= 1'b1;
		end else begin
			sync_n_d_reg <= sync_n_s;
			sclk_d_reg   <= sclk_s;
		end
	end

	assign sync_fall = sync_n_d_reg & ~sync_n_s;
	assign sclk_fall = sclk_d_reg & ~sclk_s;

	// word as it stands once the current bit is shifted in, msb first
	assign word_in = {shift_reg[22:0], sdi_s};

	// frame sequencing, capture and apply
	always @* begin
		state_next = state_reg;
		shift_next = shift_reg;
		count_next = count_reg;
		code_next  = code_reg;
		mode_next  = mode_reg;
		rcode_next = rcode_reg;
		upd_next   = 1'b0;
		abt_next   = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// only a fresh sync fall starts a word
				if (sync_fall) begin
					state_next = ST_SHIFT;
					shift_next = `DSW_SHIFT_CLEAR;
					count_next = 5'd0;
					// a clock fall seen with the sync fall is bit one
					if (sclk_fall) begin
						shift_next = {23'h00_0000, sdi_s};
						count_next = 5'd1;
					end
				end
			end
			ST_SHIFT: begin
				if (sclk_fall && count_reg == LAST_IDX[4:0]) begin
					// last bit: apply on this fall, not the 16th; a
					// sync release in the same cycle loses to it
					shift_next = word_in;
					count_next = count_reg + 5'd1;
					state_next = ST_DONE;
					upd_next   = 1'b1;
					code_next  = code_field(word_in);
					mode_next  = word_in[`DSW_MODE_HI:`DSW_MODE_LO];
					if (word_in[`DSW_RST_LOAD_BIT]) begin
						rcode_next = code_field(word_in);
					end
				end else if (sync_n_s) begin
					// sync high before the last fall drops the word;
					// level, not edge, so no path can stay stuck here
					state_next = ST_IDLE;
					shift_next = `DSW_SHIFT_CLEAR;
					count_next = 5'd0;
					abt_next   = 1'b1;
				end else if (sclk_fall) begin
					// capture one bit on each serial clock fall
					shift_next = word_in;
					count_next = count_reg + 5'd1;
				end
			end
			ST_DONE: begin
				// further clocks ignored until sync goes high
				if (sync_n_s) begin
					state_next = ST_IDLE;
					count_next = 5'd0;
				end
			end
			default: begin
				// an unused state code falls back to idle
				state_next = ST_IDLE;
				shift_next = `DSW_SHIFT_CLEAR;
				count_next = 5'd0;
			end
		endcase
	end

	// state and output registers
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			shift_reg <= `DSW_SHIFT_CLEAR;
			count_reg <= 5'd0;
			code_reg  <= POR_CODE;
			mode_reg  <= `DSW_MODE_NORMAL;
			rcode_reg <= POR_CODE;
			upd_reg   <= 1'b0;
			abt_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			count_reg <= count_next;
			code_reg  <= code_next;
			mode_reg  <= mode_next;
			rcode_reg <= rcode_next;
			upd_reg   <= upd_next;
			abt_reg   <= abt_next;
		end
	end

	// outputs from registers; power_down is decoded from mode_reg
	assign dac_code       = code_reg;
	assign power_mode_sel = mode_reg;
	assign power_down     = (mode_reg != `DSW_MODE_NORMAL);
	assign reset_code     = rcode_reg;
	assign update_pulse   = upd_reg;
	assign abort_pulse    = abt_reg;
	assign frame_active   = state_reg[1];

endmodule // dsw_write_port

`default_nettype wire

// ===== dsw_checker.sv
// dsw_checker.sv: port assertions for the dac serial write port.
// assumes it is bound to dsw_write_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dsw_checker (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        frame_sync_n,
	input wire logic [15:0] dac_code,
	input wire logic [1:0]  power_mode_sel,
	input wire logic        power_down,
	input wire logic        update_pulse,
	input wire logic        abort_pulse,
	input wire logic        frame_active
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// pulse shape, arming, holds and mode decode
	a_upd_once: assert property (update_pulse |=> !update_pulse)
		else $error("update pulse too long");
	a_abt_once: assert property (abort_pulse |=> !abort_pulse)
		else $error("abort pulse too long");
	a_no_both: assert property (!(update_pulse && abort_pulse))
		else $error("update and abort together");
	a_upd_idle: assert property (update_pulse |-> !frame_active)
		else $error("still active after update");
	a_sync_arm: assert property ($fell(frame_sync_n) |->
		##[1:6] frame_active) else $error("frame not armed");
	a_abt_keep: assert property (abort_pulse |->
		$stable({dac_code, power_mode_sel})) else $error("abort changed");
	a_code_hold: assert property (!update_pulse |->
		$stable(dac_code)) else $error("code moved without update");
	a_pd_dec: assert property (power_down == (power_mode_sel != 2'h0))
		else $error("power down decode");
endmodule // dsw_checker
bind dsw_write_port dsw_checker u_chk (.ref_clk(ref_clk), .nrst(nrst),
	.frame_sync_n(frame_sync_n), .dac_code(dac_code),
	.power_mode_sel(power_mode_sel), .power_down(power_down),
	.update_pulse(update_pulse), .abort_pulse(abort_pulse),
	.frame_active(frame_active));
`default_nettype wire

// ===== dsw_host_model.sv
// dsw_host_model.sv: host serial master for the dac write port.
// assumes calls start between frames; pins change on ref_clk falls.
`timescale 1ns/1ps
`default_nettype none
module dsw_host_model (
	input  wire logic ref_clk,
	output var  logic sync_n,
	output var  logic sclk,
	output var  logic sdin
);
	initial begin
		sync_n = 1'b1;
		sclk = 1'b1;
		sdin = 1'b0;
	end
	// half of a 200 ns serial clock period
	task automatic half;
		repeat (4) @(negedge ref_clk);
	endtask
	// n bits msb first, clock idle high outside the frame
	task automatic send(input logic [23:0] w, input int n);
		@(negedge ref_clk);
		sync_n = 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			sdin = w[i];
			half();
			sclk = 1'b0;
			half();
			sclk = 1'b1;
		end
		sdin = ~sdin; // data no longer held
		half();
		sync_n = 1'b1;
		half();
	endtask
endmodule // dsw_host_model
`default_nettype wire

// ===== tb_dsw_write_port.sv
// tb_dsw_write_port.sv: self-checking bench for the dac write port.
// assumes the host model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module tb_dsw_write_port;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	wire         sync_n;
	wire         sclk;
	wire         sdin;
	logic [15:0] code;
	logic [15:0] rcode;
	logic [1:0]  mode;
	logic        pd;
	logic        upd;
	logic        abt;
	logic        act;
	logic [15:0] code_mid;
	logic [15:0] rcode_mid;
	int          n_upd = 0;
	int          n_abt = 0;
	int          n_act = 0;
	int          upd0 = 0;
	int          abt0 = 0;
	int          act0 = 0;
	int          num_errors = 0;
	int          n_compared = 0;
	always #12.5 ref_clk = ~ref_clk;
	// count pulses and busy cycles; one writer for each counter
	always @(posedge ref_clk) begin
		if (upd === 1'b1) n_upd <= n_upd + 1;
		if (abt === 1'b1) n_abt <= n_abt + 1;
		if (act === 1'b1) n_act <= n_act + 1;
	end
	dsw_host_model host (.ref_clk(ref_clk), .sync_n(sync_n), .sclk(sclk),
		.sdin(sdin));
	dsw_write_port dut (.ref_clk(ref_clk), .nrst(nrst),
		.frame_sync_n(sync_n), .serial_clock(sclk), .serial_data_in(sdin),
		.dac_code(code), .power_mode_sel(mode), .power_down(pd),
		.reset_code(rcode), .update_pulse(upd), .abort_pulse(abt),
		.frame_active(act));
	// midscale power-on variant listening on the same pins
	dsw_write_port #(.RESET_TO_MID(1)) dut_mid (.ref_clk(ref_clk),
		.nrst(nrst), .frame_sync_n(sync_n), .serial_clock(sclk),
		.serial_data_in(sdin), .dac_code(code_mid), .power_mode_sel(),
		.power_down(), .reset_code(rcode_mid), .update_pulse(),
		.abort_pulse(), .frame_active());
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic frame(input logic [23:0] w, input int n);
		upd0 = n_upd;
		abt0 = n_abt;
		act0 = n_act;
		host.send(w, n);
		repeat (6) @(negedge ref_clk);
		chk({15'h0, n_act != act0}, 16'h0001);
		chk({15'h0, act}, 16'h0000);
	endtask
	// every mode with stray bits 19:16 set
	task automatic t_modes;
		for (int i = 0; i < 4; i++) begin
			frame({2'b00, 2'(i), 4'hF, 16'(i * 16'h1111)}, 24);
			chk(code, 16'(i * 16'h1111));
			chk({14'h0, mode}, 16'(i));
			chk({15'h0, pd}, {15'h0, i != 0});
			chk(rcode, 16'h0000);
			chk(16'(n_upd - upd0), 16'h0001);
		end
	endtask
	// reset-code load, then a 23-bit abort and a clean recovery
	task automatic t_load_abort;
		frame(24'h40_ABCD, 24);
		chk(rcode, 16'hABCD);
		chk(code_mid, 16'hABCD);
		frame(24'h70_5A5A, 23);
		chk(code, 16'hABCD);
		chk({14'h0, mode}, 16'h0000);
		chk(16'(n_abt - abt0), 16'h0001);
		chk(16'(n_upd - upd0), 16'h0000);
		frame(24'h00_0F0F, 24);
		chk(code, 16'h0F0F);
		chk(rcode, 16'hABCD);
	endtask
	// a mid-run reset restores both power-on codes and clears the rest
	task automatic t_reset;
		frame(24'h70_1234, 24);
		nrst = 1'b0;
		@(negedge ref_clk);
		chk(code, 16'h0000);
		chk(code_mid, 16'h8000);
		chk(rcode, 16'h0000);
		chk({14'h0, mode}, 16'h0000);
		repeat (9) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(rcode_mid, 16'h8000);
		frame(24'h00_0001, 24);
		chk(code_mid, 16'h0001);
	endtask
	task automatic close_out;
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(code, 16'h0000);
		chk(code_mid, 16'h8000);
		t_modes();
		t_load_abort();
		t_reset();
		close_out();
	end
	// watchdog at about four times the expected run of some 47 us
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
endmodule // tb_dsw_write_port
`default_nettype wire
